// *** rtl/dms_supervisor.sv ***
/*
  Hold-to-run flow supervisor with APB register access.
  Assumes handle, alarm, reset-switch and bypass inputs are already
  synchronous to clk_sys_i and debounced outside.
*/
`timescale 1ns/10ps

module dms_supervisor #(
  parameter int unsigned TICK_CYC = dms_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Field inputs
  input  wire logic        handle_i,
  input  wire logic        press_alarm_i,
  input  wire logic        alarm_reset_i,
  input  wire logic        bypass_i,
  // Field outputs
  output logic             valve_o,
  output logic             lamp_o,
  output logic             sounder_o,
  output logic             push_prompt_o
);

  typedef struct packed {
    dms_pkg::dms_state_t state;
    logic [31:0] ctrl;
    logic [31:0] pol;
    logic [31:0] act;
    logic [31:0] tmo;
    logic [31:0] rel;
    logic [31:0] blink;
    logic [31:0] prdata;
    logic [31:0] tick_cnt;
    logic [31:0] tmr;
    logic [31:0] dem_tmr;
    logic [31:0] blink_cnt;
    logic        blink_ph;
    logic        alarm;
    logic        hdl_q;
    logic        released;
    logic        valve;
    logic        lamp;
    logic        sounder;
    logic        prompt;
    logic        pwd_clr;
  } dms_regs_t;

  dms_regs_t r;
  dms_regs_t next_r;

  logic [3:0] pin_in;
  logic       hdl;
  logic       alm_in;
  logic       sw_rst;
  logic       byp;
  logic       tick;
  logic       press_edge;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic [31:0] stat;

  // Input polarity applied before any use
  assign pin_in = {bypass_i, alarm_reset_i, press_alarm_i, handle_i}
                ^ r.pol[dms_pkg::POL_IN_LSB +: 4];
  assign hdl    = pin_in[0];
  assign alm_in = pin_in[1];
  assign sw_rst = pin_in[2];
  assign byp    = pin_in[3];

  assign tick       = (r.tick_cnt == 32'(TICK_CYC - 1));
  assign press_edge = hdl & ~r.hdl_q;

  // Zero-wait APB; all offsets decoded, others answer with an error
  assign addr_ok  = (paddr_i[1:0] == 2'b00) && (paddr_i <= dms_pkg::OFS_ARST);
  assign wr_en    = psel_i & penable_i & pwrite_i & addr_ok;
  assign rd_en    = psel_i & ~penable_i & ~pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign prdata_o  = r.prdata;

  always_comb begin
    stat = 32'h0000_0000;
    stat[dms_pkg::ST_HANDLE] = hdl;
    stat[dms_pkg::ST_FLOW]   = r.valve;
    stat[dms_pkg::ST_LAMP]   = r.lamp;
    stat[dms_pkg::ST_SOUND]  = r.sounder;
    stat[dms_pkg::ST_ALARM]  = r.alarm;
    stat[dms_pkg::ST_BYPASS] = byp;
    stat[dms_pkg::ST_PROMPT] = r.prompt;
    stat[dms_pkg::ST_STATE +: 3] = r.state;
  end

  always_comb begin
    next_r = r;
    next_r.hdl_q   = hdl;
    next_r.pwd_clr = 1'b0;

    // Common timebase
    next_r.tick_cnt = tick ? 32'h0000_0000 : r.tick_cnt + 32'h0000_0001;

    // Register writes
    if (wr_en) begin
      unique case (paddr_i)
        dms_pkg::OFS_CTRL:  next_r.ctrl  = pwdata_i;
        dms_pkg::OFS_POL:   next_r.pol   = pwdata_i;
        dms_pkg::OFS_ACT:   next_r.act   = pwdata_i;
        dms_pkg::OFS_TMO:   next_r.tmo   = pwdata_i;
        dms_pkg::OFS_REL:   next_r.rel   = pwdata_i;
        dms_pkg::OFS_BLINK: next_r.blink = pwdata_i;
        dms_pkg::OFS_ARST:  next_r.pwd_clr = (pwdata_i == dms_pkg::ARST_KEY);
        default: ;
      endcase
    end

    // Read data captured in setup phase, held through access
    if (rd_en) begin
      unique case (paddr_i)
        dms_pkg::OFS_CTRL:  next_r.prdata = r.ctrl;
        dms_pkg::OFS_POL:   next_r.prdata = r.pol;
        dms_pkg::OFS_ACT:   next_r.prdata = r.act;
        dms_pkg::OFS_TMO:   next_r.prdata = r.tmo;
        dms_pkg::OFS_REL:   next_r.prdata = r.rel;
        dms_pkg::OFS_BLINK: next_r.prdata = r.blink;
        dms_pkg::OFS_STAT:  next_r.prdata = stat;
        default:            next_r.prdata = 32'h0000_0000;
      endcase
    end

    // Alarm latch; a new alarm wins over a clear in the same cycle
    if (r.alarm &&
        (r.ctrl[dms_pkg::CTRL_PWD_MODE] ? r.pwd_clr : sw_rst)) begin
      next_r.alarm = 1'b0;
    end
    if (alm_in) begin
      next_r.alarm = 1'b1;
    end

    // Blink phase generator, restarted outside a blink demand
    if (r.state != dms_pkg::ST_DEMAND && !r.alarm) begin
      next_r.blink_cnt = 32'h0000_0000;
      next_r.blink_ph  = 1'b1;
    end else if (tick) begin
      // Half period per phase, so one full cycle per blink period
      if (r.blink_cnt + 32'h0000_0001 >= (r.blink >> 1)) begin
        next_r.blink_cnt = 32'h0000_0000;
        next_r.blink_ph  = ~r.blink_ph;
      end else begin
        next_r.blink_cnt = r.blink_cnt + 32'h0000_0001;
      end
    end

    if (tick && r.tmr != 32'h0000_0000) begin
      next_r.tmr = r.tmr - 32'h0000_0001;
    end
    if (tick && r.dem_tmr != 32'h0000_0000) begin
      next_r.dem_tmr = r.dem_tmr - 32'h0000_0001;
    end

    // Supervision sequence
    unique case (r.state)
      dms_pkg::ST_IDLE: begin
        if (press_edge && !r.alarm && !alm_in) begin
          next_r.state = dms_pkg::ST_RUN;
          next_r.tmr   = r.act;
        end
      end
      dms_pkg::ST_RUN: begin
        if (!hdl) begin
          next_r.state = dms_pkg::ST_RELWAIT;
          next_r.tmr   = r.rel;
          next_r.released = 1'b0;
        end else if (tick && r.tmr <= 32'h0000_0001) begin
          next_r.state   = dms_pkg::ST_DEMAND;
          next_r.dem_tmr = r.tmo;
          next_r.released = 1'b0;
        end
      end
      dms_pkg::ST_DEMAND: begin
        if (!hdl) begin
          next_r.released = 1'b1;
        end
        if (r.released && press_edge) begin
          next_r.state = dms_pkg::ST_RUN;
          next_r.tmr   = r.act;
        end else if (tick && r.dem_tmr <= 32'h0000_0001) begin
          next_r.state = dms_pkg::ST_IDLE;
        end
      end
      dms_pkg::ST_RELWAIT: begin
        if (hdl) begin
          next_r.state = dms_pkg::ST_RUN;
          next_r.tmr   = r.act;
        end else if (tick && r.tmr <= 32'h0000_0001) begin
          next_r.state = dms_pkg::ST_IDLE;
        end
      end
      dms_pkg::ST_LOCKED: begin
        // Held here until the alarm is gone; fresh press needed after
        if (!r.alarm) begin
          next_r.state = dms_pkg::ST_IDLE;
        end
      end
      default: next_r.state = dms_pkg::ST_IDLE;
    endcase

    // Alarm overrides any flow state
    if (alm_in || r.alarm) begin
      next_r.state = dms_pkg::ST_LOCKED;
    end

    // Output decode, logical polarity
    next_r.valve   = 1'b0;
    next_r.lamp    = 1'b0;
    next_r.sounder = 1'b0;
    next_r.prompt  = 1'b0;
    if (byp) begin
      next_r.valve = 1'b1;
      next_r.lamp  = 1'b1;
    end else if (next_r.state == dms_pkg::ST_LOCKED) begin
      next_r.lamp    = next_r.blink_ph;
      next_r.sounder = 1'b1;
    end else begin
      unique case (next_r.state)
        dms_pkg::ST_RUN: begin
          next_r.valve = 1'b1;
          next_r.lamp  = 1'b1;
        end
        dms_pkg::ST_RELWAIT: begin
          next_r.valve = 1'b1;
          next_r.lamp  = 1'b1;
        end
        dms_pkg::ST_DEMAND: begin
          next_r.valve   = 1'b1;
          next_r.lamp    = next_r.blink_ph;
          next_r.sounder = 1'b1;
          next_r.prompt  = r.ctrl[dms_pkg::CTRL_DISP_EN];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r           <= '0;
      r.state     <= dms_pkg::ST_IDLE;
      r.ctrl      <= dms_pkg::CTRL_RST;
      r.pol       <= dms_pkg::POL_RST;
      r.act       <= dms_pkg::ACT_RST;
      r.tmo       <= dms_pkg::TMO_RST;
      r.rel       <= dms_pkg::REL_RST;
      r.blink     <= dms_pkg::BLINK_RST;
      r.blink_ph  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Output polarity applied at the pins
  assign valve_o       = r.valve   ^ r.pol[dms_pkg::POL_OUT_LSB];
  assign lamp_o        = r.lamp    ^ r.pol[dms_pkg::POL_OUT_LSB + 1];
  assign sounder_o     = r.sounder ^ r.pol[dms_pkg::POL_OUT_LSB + 2];
  assign push_prompt_o = r.prompt  ^ r.pol[dms_pkg::POL_OUT_LSB + 3];

endmodule : dms_supervisor

// *** rtl/dms_pkg.sv ***
/*
  Package for the hold-to-run flow supervisor: APB register map, field
  positions, reset values, timing figures and the state encoding.
  Assumes a 50 MHz system clock and a 32-bit APB slave.
*/
package dms_pkg;

  // Clock and timebase
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;

  // Timing figures in milliseconds, converted to ticks of one millisecond
  localparam int unsigned ACT_MS        = 90_000;
  localparam int unsigned TMO_MS        = 30_000;
  localparam int unsigned REL_MS        = 500;
  localparam int unsigned BLINK_MS      = 1_000;
  localparam int unsigned TICKS_PER_MS  = 1000 / TICK_US;

  localparam logic [31:0] ACT_RST   = 32'(ACT_MS * TICKS_PER_MS);
  localparam logic [31:0] TMO_RST   = 32'(TMO_MS * TICKS_PER_MS);
  localparam logic [31:0] REL_RST   = 32'(REL_MS * TICKS_PER_MS);
  localparam logic [31:0] BLINK_RST = 32'(BLINK_MS * TICKS_PER_MS);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_POL    = 8'h04;
  localparam logic [7:0] OFS_ACT    = 8'h08;
  localparam logic [7:0] OFS_TMO    = 8'h0C;
  localparam logic [7:0] OFS_REL    = 8'h10;
  localparam logic [7:0] OFS_BLINK  = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;
  localparam logic [7:0] OFS_ARST   = 8'h1C;

  // Control fields
  localparam int unsigned CTRL_PWD_MODE = 0;
  localparam int unsigned CTRL_DISP_EN  = 1;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;

  // Polarity fields: inputs 3:0, outputs 11:8
  localparam int unsigned POL_IN_LSB  = 0;
  localparam int unsigned POL_OUT_LSB = 8;
  localparam logic [31:0] POL_RST     = 32'h0000_0000;

  // Password-authorised alarm reset key
  localparam logic [31:0] ARST_KEY    = 32'h0000_A55A;

  // Status fields
  localparam int unsigned ST_HANDLE  = 0;
  localparam int unsigned ST_FLOW    = 1;
  localparam int unsigned ST_LAMP    = 2;
  localparam int unsigned ST_SOUND   = 3;
  localparam int unsigned ST_ALARM   = 4;
  localparam int unsigned ST_BYPASS  = 5;
  localparam int unsigned ST_PROMPT  = 6;
  localparam int unsigned ST_STATE   = 8;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RUN     = 3'b001,
    ST_DEMAND  = 3'b010,
    ST_RELWAIT = 3'b011,
    ST_LOCKED  = 3'b100
  } dms_state_t;

endpackage : dms_pkg

// *** verification/dms_supervisor_props.sv ***
/* Port checker for the flow supervisor, bound below.
   Assumes output polarity bits stay at their reset value. */
`timescale 1ns/10ps
module dms_supervisor_props (
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic       handle_i,
  input wire logic       press_alarm_i,
  input wire logic       bypass_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic       valve_o,
  input wire logic       lamp_o,
  input wire logic       sounder_o,
  input wire logic       push_prompt_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  a_alarm_shuts: assert property (
    press_alarm_i && !bypass_i ##1 !bypass_i |=> !valve_o) else $error("open");
  a_alarm_sounds: assert property (
    press_alarm_i && !bypass_i ##1 !bypass_i |=> sounder_o) else $error("mute");
  a_bypass_outs: assert property (
    bypass_i ##1 bypass_i |-> valve_o && lamp_o && !sounder_o)
    else $error("bypass outputs");
  a_short_release: assert property (
    valve_o && handle_i && !press_alarm_i ##1 !handle_i && !press_alarm_i
    ##1 handle_i && !press_alarm_i |=> valve_o) else $error("dropped");
  a_fresh_press: assert property (
    !valve_o && handle_i && $past(handle_i) && !bypass_i ##1 !bypass_i
    |-> !valve_o) else $error("no fresh press");
  a_prompt_demand: assert property (
    !bypass_i ##1 push_prompt_o |-> sounder_o) else $error("prompt");
  a_valve_cause: assert property (
    $rose(valve_o) |-> $past(handle_i) || $past(bypass_i)) else $error("rose");
  a_apb_answer: assert property (
    psel_i && penable_i |-> pready_o && (pslverr_o ==
    (paddr_i > 8'h1C || paddr_i[1:0] != 2'b00))) else $error("apb");
  c_demand: cover property (valve_o && sounder_o);
  c_locked: cover property (!valve_o && sounder_o && !bypass_i);
  c_bypass: cover property (bypass_i && valve_o);
endmodule : dms_supervisor_props

bind dms_supervisor dms_supervisor_props i_props (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .handle_i(handle_i),
  .press_alarm_i(press_alarm_i), .bypass_i(bypass_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .valve_o(valve_o), .lamp_o(lamp_o),
  .sounder_o(sounder_o), .push_prompt_o(push_prompt_o));

// *** verification/dms_field_model.sv ***
/* Operator handle and pressure gauge facing the supervisor.
   Assumes bench commands change just after a rising edge. */
`timescale 1ns/10ps
module dms_field_model (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  // Bench commands and sounder
  input  wire logic hold_i,
  input  wire logic obey_i,
  input  wire logic gauge_i,
  input  wire logic sounder_i,
  // Contacts
  output logic      handle_o,
  output logic      press_alarm_o
);
  logic snd_q;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {snd_q, handle_o, press_alarm_o} <= '0;
    end else begin
      snd_q <= sounder_i;
      // One-cycle let-go, far inside any timeout
      handle_o <= hold_i && !(obey_i && sounder_i && !snd_q);
      press_alarm_o <= gauge_i;
    end
  end
endmodule : dms_field_model

// *** verification/tb.sv ***
/* Bench for the flow supervisor: APB master, field model, checks.
   Assumes the checker is attached by its bind. */
`timescale 1ns/10ps
module tb;
  localparam int unsigned TK = 4;
  logic        clk_sys_i, reset_n_i, psel, penable, pwrite, pready, err;
  logic        pslverr, hold, obey, gauge, unlock, byp, handle, p_alarm;
  logic        valve, lamp, sounder, prompt;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          bad_count, checks, tog;
  dms_supervisor #(.TICK_CYC(TK)) i_dut (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .handle_i(handle), .press_alarm_i(p_alarm), .alarm_reset_i(unlock),
    .bypass_i(byp), .valve_o(valve), .lamp_o(lamp), .sounder_o(sounder),
    .push_prompt_o(prompt));
  dms_field_model i_field (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .hold_i(hold), .obey_i(obey), .gauge_i(gauge), .sounder_i(sounder),
    .handle_o(handle), .press_alarm_o(p_alarm));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    // A missing answer counts against the run
    if (pready !== 1'b1) begin
      bad_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Bounded wait on valve (sel 1) or sounder
  task automatic wt(input bit sel, input logic v);
    int n;
    n = 0;
    while ((sel ? valve : sounder) !== v && n < 80) begin
      @(posedge clk_sys_i);
      n++;
    end
    if ((sel ? valve : sounder) !== v) begin
      bad_count++;
    end
  endtask : wt
  task automatic blinks();
    logic l;
    tog = 0;
    l = lamp;
    repeat (3 * TK) begin
      @(posedge clk_sys_i);
      tog += int'(lamp !== l);
      l = lamp;
    end
  endtask : blinks
  task automatic hit();
    gauge <= 1'b1;
    cyc(1);
    gauge <= 1'b0;
    wt(1, 0);
  endtask : hit
  task automatic t_regs();
    logic [31:0] ex [6];
    logic [31:0] wv [6];
    ex = '{dms_pkg::CTRL_RST, dms_pkg::POL_RST, dms_pkg::ACT_RST,
           dms_pkg::TMO_RST, dms_pkg::REL_RST, dms_pkg::BLINK_RST};
    wv = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0004, 32'h0000_0006,
           32'h0000_0002, 32'h0000_0002};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), '0);
      chk(rd, ex[i]);
      apb(1'b1, 8'(4 * i), wv[i]);
      apb(1'b0, 8'(4 * i), '0);
      chk(rd, wv[i]);
    end
    apb(1'b0, dms_pkg::OFS_STAT, '0);
    chk(rd, '0);
    apb(1'b0, 8'h20, '0);
    chk(rd, '0);
    chk(err, 1);
  endtask : t_regs
  task automatic t_timeout();
    hold <= 1'b1;
    wt(1, 1);
    chk({valve, lamp, sounder}, 3'b110);
    apb(1'b0, dms_pkg::OFS_STAT, '0);
    chk(rd, 32'h0000_0107);
    cyc(TK);
    chk(sounder, 0);
    wt(0, 1);
    chk({valve, prompt}, 2'b11);
    blinks();
    chk(tog >= 2, 1);
    chk(valve, 1);
    wt(1, 0);
    cyc(8);
    chk({valve, sounder}, 2'b00);
    // Let the handle fall so the next scenario starts with a fresh press
    hold <= 1'b0;
    cyc(4);
  endtask : t_timeout
  task automatic t_repress();
    obey <= 1'b1;
    hold <= 1'b1;
    wt(1, 1);
    wt(0, 1);
    wt(0, 0);
    cyc(8 * TK);
    chk(valve, 1);
    obey <= 1'b0;
    hold <= 1'b0;
    cyc(TK);
    chk(valve, 1);
    wt(1, 0);
    chk({valve, lamp}, 2'b00);
  endtask : t_repress
  task automatic t_alarm();
    hold <= 1'b1;
    wt(1, 1);
    hit();
    chk({valve, sounder}, 2'b01);
    blinks();
    chk(tog >= 2, 1);
    byp <= 1'b1;
    cyc(4);
    chk({valve, lamp, sounder}, 3'b110);
    byp <= 1'b0;
    unlock <= 1'b1;
    cyc(4);
    chk({valve, sounder}, 2'b00);
    unlock <= 1'b0;
    hold <= 1'b0;
    cyc(4);
    hold <= 1'b1;
    wt(1, 1);
    chk(valve, 1);
    apb(1'b1, dms_pkg::OFS_CTRL, 32'h0000_0003);
    hit();
    unlock <= 1'b1;
    cyc(4);
    unlock <= 1'b0;
    chk(sounder, 1);
    apb(1'b1, dms_pkg::OFS_ARST, dms_pkg::ARST_KEY);
    cyc(3);
    chk(sounder, 0);
  endtask : t_alarm
  // Lamp and sounder pins inverted while idle, valve left alone
  task automatic t_pol();
    apb(1'b1, dms_pkg::OFS_POL, 32'h0000_0600);
    cyc(1);
    chk({valve, lamp, sounder}, 3'b011);
    apb(1'b1, dms_pkg::OFS_POL, 32'h0000_0000);
    cyc(1);
    chk({valve, lamp, sounder}, 3'b000);
  endtask : t_pol
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {reset_n_i, psel, penable, pwrite, hold, obey, gauge, unlock, byp} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_timeout();
    t_repress();
    t_alarm();
    t_pol();
    final_report();
  end
  // Whole run is a few hundred cycles
  initial begin
    cyc(4000);
    bad_count++;
    final_report();
  end
endmodule : tb
